// ===== src/twa_top.v
// Added by the designer: the Avalon-MM interface to the registers and the register offsets.
`timescale 1ns/1ps
`include "twa_consts.vh"

module twa_top #(
   parameter [23:0] TICK_CYCLES = `TWA_TICK_CYCLES
) (
   input  wire        mclk,
   input  wire        rst_n,
   input  wire [7:0]  avs_address,
   input  wire        avs_read,
   input  wire        avs_write,
   input  wire [31:0] avs_writedata,
   input  wire [3:0]  avs_byteenable,
   output reg  [31:0] avs_readdata,
   output wire        avs_waitrequest,
   input  wire [71:0] in_val_flat,
   input  wire [3:0]  wire_run,
   input  wire [3:0]  wire_hold,
   input  wire [3:0]  wire_reset,
   output wire [71:0] total_flat,
   output wire [3:0]  alarm,
   output wire        update_tick
);

   reg  [6:0]  ctrl [0:3];
   reg  [17:0] sp_q [0:3];
   reg  [3:0]  sw_rst;
   reg  [3:0]  sp_chg;
   reg         ack;
   reg  [23:0] tick_cnt;
   reg         tick;

   wire [1:0]  ch;
   wire [3:0]  reg_off;
   wire        mapped;
   wire        wr_go;
   wire [3:0]  eff_run;
   wire [3:0]  eff_hold;
   wire [3:0]  eff_zero;
   wire [3:0]  running;
   wire [17:0] sp_new;
   wire [31:0] sp_word;
   wire [3:0]  ctrl_wr;
   wire [3:0]  sp_wr;
   reg  [31:0] next_readdata;

   integer i;

   // ***********************************************
   // helpers
   // ***********************************************
   // wired source wins when selected
   function pick;
      input wired_sel;
      input wired_val;
      input sw_val;
      begin
         pick = wired_sel ? wired_val : sw_val;
      end
   endfunction

   // byte-lane merge of a 32-bit write
   function [31:0] merge;
      input [31:0] old;
      input [31:0] wdata;
      input [3:0]  be;
      integer k;
      begin
         merge = old;
         for (k = 0; k < 4; k = k + 1)
         begin
            if (be[k])
               merge[k*8 +: 8] = wdata[k*8 +: 8];
         end
      end
   endfunction

   // stored control bits; the reset bit is a pulse and reads 0
   function [6:0] ctrl_pack;
      input [31:0] wdata;
      begin
         ctrl_pack                      = 7'h00;
         ctrl_pack[`TWA_CTRL_RUN]       = wdata[`TWA_CTRL_RUN];
         ctrl_pack[`TWA_CTRL_HOLD]      = wdata[`TWA_CTRL_HOLD];
         ctrl_pack[`TWA_CTRL_RUN_WIRE]  = wdata[`TWA_CTRL_RUN_WIRE];
         ctrl_pack[`TWA_CTRL_HOLD_WIRE] = wdata[`TWA_CTRL_HOLD_WIRE];
         ctrl_pack[`TWA_CTRL_RST_WIRE]  = wdata[`TWA_CTRL_RST_WIRE];
      end
   endfunction

   // status word from the channel flags
   function [31:0] stat_word;
      input alm;
      input run_now;
      input held;
      begin
         stat_word                    = 32'h00000000;
         stat_word[`TWA_STAT_ALARM]   = alm;
         stat_word[`TWA_STAT_RUNNING] = run_now;
         stat_word[`TWA_STAT_HELD]    = held;
      end
   endfunction

   // one-hot select of the addressed channel
   function [3:0] ch_sel;
      input [1:0] c;
      begin
         ch_sel    = 4'h0;
         ch_sel[c] = 1'b1;
      end
   endfunction

   // ***********************************************
   // bus decode, one wait state on every access
   // ***********************************************
   assign ch              = avs_address[`TWA_CH_SHIFT+1:`TWA_CH_SHIFT];
   assign reg_off         = avs_address[`TWA_CH_SHIFT-1:0];
   assign mapped          = (avs_address[7:6] == 2'b00);
   assign avs_waitrequest = (avs_read | avs_write) & ~ack;
   assign wr_go           = avs_write & ack & mapped;
   // total and status ignore writes
   assign ctrl_wr         = (wr_go && (reg_off == `TWA_OFF_CTRL) && avs_byteenable[0]) ?
                            ch_sel(ch) : 4'h0;
   assign sp_wr           = (wr_go && (reg_off == `TWA_OFF_SP)) ? ch_sel(ch) : 4'h0;
   assign sp_word         = merge({14'h0000, sp_q[ch]}, avs_writedata, avs_byteenable);
   assign sp_new          = sp_word[17:0];

   always @(posedge mclk or negedge rst_n)
   begin
      if (!rst_n)
         ack <= 1'b0;
      else if (ack)
         ack <= 1'b0;
      else
         ack <= avs_read | avs_write;
   end

   // ***********************************************
   // read data, registered before the answer cycle
   // ***********************************************
   always @*
   begin
      next_readdata = 32'h00000000;
      if (mapped)
      begin
         case (reg_off)
            `TWA_OFF_CTRL:
               next_readdata = {25'h0000000, ctrl[ch]};
            `TWA_OFF_SP:
               next_readdata = {14'h0000, sp_q[ch]};
            `TWA_OFF_TOTAL:
               next_readdata = {14'h0000, total_flat[ch*18 +: 18]};
            `TWA_OFF_STAT:
               next_readdata = stat_word(alarm[ch], running[ch],
                                         eff_hold[ch] & eff_run[ch]);
            default:
               next_readdata = 32'h00000000;
         endcase
      end
   end

   always @(posedge mclk or negedge rst_n)
   begin
      if (!rst_n)
         avs_readdata <= 32'h00000000;
      else if (avs_read && !ack)
         avs_readdata <= next_readdata;
   end

   // ***********************************************
   // control and setpoint registers
   // ***********************************************
   always @(posedge mclk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         for (i = 0; i < 4; i = i + 1)
         begin
            ctrl[i] <= `TWA_CTRL_RST_VAL;
            sp_q[i] <= `TWA_SP_RST_VAL;
         end
         sw_rst <= 4'h0;
         sp_chg <= 4'h0;
      end
      else
      begin
         sw_rst <= 4'h0;
         sp_chg <= 4'h0;
         for (i = 0; i < 4; i = i + 1)
         begin
            if (ctrl_wr[i])
            begin
               ctrl[i]   <= ctrl_pack(avs_writedata);
               sw_rst[i] <= avs_writedata[`TWA_CTRL_RESET];
            end
            if (sp_wr[i])
            begin
               sp_q[i]   <= sp_new;
               sp_chg[i] <= (sp_new != sp_q[i]);
            end
         end
      end
   end

   // ***********************************************
   // update tick
   // ***********************************************
   always @(posedge mclk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         tick_cnt <= 24'h000000;
         tick     <= 1'b0;
      end
      else if (tick_cnt == TICK_CYCLES - 24'h000001)
      begin
         tick_cnt <= 24'h000000;
         tick     <= 1'b1;
      end
      else
      begin
         tick_cnt <= tick_cnt + 24'h000001;
         tick     <= 1'b0;
      end
   end

   assign update_tick = tick;

   // ***********************************************
   // four channels
   // ***********************************************
   genvar g;
   generate
      for (g = 0; g < 4; g = g + 1)
      begin : chan
         assign eff_run[g]  = pick(ctrl[g][`TWA_CTRL_RUN_WIRE],
                                   wire_run[g],
                                   ctrl[g][`TWA_CTRL_RUN]);
         assign eff_hold[g] = pick(ctrl[g][`TWA_CTRL_HOLD_WIRE],
                                   wire_hold[g],
                                   ctrl[g][`TWA_CTRL_HOLD]);
         assign eff_zero[g] = pick(ctrl[g][`TWA_CTRL_RST_WIRE],
                                   wire_reset[g],
                                   sw_rst[g]);

         twa_channel u_ch (
            .mclk    (mclk),
            .rst_n   (rst_n),
            .tick    (tick),
            .run     (eff_run[g]),
            .hold    (eff_hold[g]),
            .zero    (eff_zero[g]),
            .sp_chg  (sp_chg[g]),
            .sp      (sp_q[g]),
            .in_val  (in_val_flat[g*18 +: 18]),
            .total   (total_flat[g*18 +: 18]),
            .alarm   (alarm[g]),
            .running (running[g])
         );
      end
   endgenerate

endmodule // twa_top

// ===== src/twa_consts.vh
`ifndef TWA_CONSTS_VH
`define TWA_CONSTS_VH

// ***********************************************
// register map, byte addresses
// ***********************************************
`define TWA_CH_SHIFT       4
`define TWA_OFF_CTRL       4'h0
`define TWA_OFF_SP         4'h4
`define TWA_OFF_TOTAL      4'h8
`define TWA_OFF_STAT       4'hc

// ***********************************************
// control fields
// ***********************************************
`define TWA_CTRL_RUN       0
`define TWA_CTRL_HOLD      1
`define TWA_CTRL_RESET     2
`define TWA_CTRL_RUN_WIRE  4
`define TWA_CTRL_HOLD_WIRE 5
`define TWA_CTRL_RST_WIRE  6
`define TWA_CTRL_RST_VAL   7'h02
`define TWA_SP_RST_VAL     18'h00000

// ***********************************************
// status fields
// ***********************************************
`define TWA_STAT_ALARM     0
`define TWA_STAT_RUNNING   1
`define TWA_STAT_HELD      2

// ***********************************************
// arithmetic and timing
// ***********************************************
`define TWA_VAL_W          18
`define TWA_FRAC_BITS      10
`define TWA_TOTAL_MAX      32'sd99999
`define TWA_TOTAL_MIN      -32'sd9999
`define TWA_CLK_PERIOD_NS  8
`define TWA_TICK_NS        1000000
// 1 ms of 8 ns cycles
`define TWA_TICK_CYCLES    24'd125000

`endif

// ===== src/twa_channel.v
`timescale 1ns/1ps
`include "twa_consts.vh"

module twa_channel (
   input  wire        mclk,
   input  wire        rst_n,
   input  wire        tick,
   input  wire        run,
   input  wire        hold,
   input  wire        zero,
   input  wire        sp_chg,
   input  wire [17:0] sp,
   input  wire [17:0] in_val,
   output wire [17:0] total,
   output reg         alarm,
   output wire        running
);

   localparam signed [31:0] ACC_MAX = `TWA_TOTAL_MAX <<< `TWA_FRAC_BITS;
   localparam signed [31:0] ACC_MIN = `TWA_TOTAL_MIN <<< `TWA_FRAC_BITS;

   reg  signed [31:0] acc;
   wire signed [31:0] in_ext;
   wire signed [17:0] tot_s;
   wire signed [17:0] sp_s;
   wire               hit;

   // ***********************************************
   // clamp to the total limits
   // ***********************************************
   function signed [31:0] clamp;
      input signed [31:0] v;
      begin
         if (v > ACC_MAX)
            clamp = ACC_MAX;
         else if (v < ACC_MIN)
            clamp = ACC_MIN;
         else
            clamp = v;
      end
   endfunction

   assign running = run & ~hold;
   assign in_ext  = {{14{in_val[17]}}, in_val};
   assign total   = acc[`TWA_FRAC_BITS+17:`TWA_FRAC_BITS];
   assign tot_s   = total;
   assign sp_s    = sp;

   // ***********************************************
   // integration, one tick is one time-base unit
   // ***********************************************
   always @(posedge mclk or negedge rst_n)
   begin
      if (!rst_n)
         acc <= 32'sd0;
      else if (zero)
         acc <= 32'sd0;
      else if (tick && running)
         acc <= clamp(acc + in_ext);
      // otherwise frozen
   end

   // ***********************************************
   // alarm, latched, evaluated in run and hold
   // ***********************************************
   assign hit = ((sp_s > 18'sd0) && (tot_s > sp_s)) ||
                ((sp_s < 18'sd0) && (tot_s < sp_s));

   always @(posedge mclk or negedge rst_n)
   begin
      if (!rst_n)
         alarm <= 1'b0;
      else if (zero || (sp_s == 18'sd0))
         alarm <= 1'b0;
      else if (hit)
         alarm <= 1'b1;
      else if (sp_chg)
         alarm <= 1'b0;
   end

endmodule // twa_channel

// ===== verif/twa_chk_assertions.sv
`timescale 1ns/1ps
// ***********
// checker
// ***********
module twa_chk #(
   parameter [23:0] TICK_CYCLES = 24'd8
) (
   input wire        mclk,
   input wire        rst_n,
   input wire [7:0]  avs_address,
   input wire        avs_write,
   input wire [31:0] avs_writedata,
   input wire        avs_waitrequest,
   input wire [3:0]  wire_reset,
   input wire [71:0] total_flat,
   input wire [3:0]  alarm,
   input wire        update_tick
);
   wire signed [17:0] t0 = total_flat[17:0];
   wire signed [17:0] t1 = total_flat[35:18];
   wire signed [17:0] t2 = total_flat[53:36];
   wire               wr_ok = avs_write & ~avs_waitrequest;
   logic [23:0]       gap;
   logic              seen;
   logic [3:0]        since;
   always_ff @(posedge mclk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         gap <= 24'h0;
         seen <= 1'b0;
         since <= 4'h0;
      end
      else
      begin
         gap <= update_tick ? 24'h1 : gap + 24'h1;
         seen <= seen | update_tick;
         since <= (wr_ok | wire_reset[0]) ? 4'h0 : since + {3'h0, since != 4'hf};
      end
   end
   default clocking @(posedge mclk); endclocking
   default disable iff (!rst_n);
   sequence s_swrst;
      wr_ok && avs_address == 8'h00 && avs_writedata[2] && !avs_writedata[6];
   endsequence
   sequence s_sp_zero;
      wr_ok && avs_address == 8'h04 && avs_writedata[17:0] == 18'h0;
   endsequence
   AST_CLAMP_HI: assert property (t0 <= 18'sd99999 && t1 <= 18'sd99999)
      else $error("total above upper limit");
   AST_CLAMP_LO: assert property (t0 >= -18'sd9999 && t2 >= -18'sd9999)
      else $error("total below lower limit");
   AST_TICK: assert property (update_tick && seen |-> gap == TICK_CYCLES)
      else $error("update tick spacing wrong");
   AST_NO_ADD: assert property ($changed(t0) && t0 != 18'sh0 |->
      $past(update_tick) || $past(update_tick, 2)) else $error("total moved without tick");
   AST_ALRM_SET: assert property ($rose(alarm[0]) |-> t0 != 18'sh0)
      else $error("alarm set at zero total");
   AST_ALRM_LATCH: assert property ($fell(alarm[0]) |-> since < 4'd5)
      else $error("alarm cleared without cause");
   AST_RST_OFF: assert property ($rose(rst_n) |-> alarm == 4'h0 && total_flat == 72'h0)
      else $error("state not cleared by reset");
   AST_SWRST: assert property (s_swrst |-> ##[1:3] (t0 == 18'sh0 && !alarm[0]))
      else $error("soft reset did not clear");
   AST_SP_ZERO: assert property (s_sp_zero |-> ##3 !alarm[0] [*4])
      else $error("alarm on with zero setpoint");
endmodule // twa_chk
bind twa_top twa_chk #(.TICK_CYCLES(TICK_CYCLES)) u_chk (
   .mclk(mclk), .rst_n(rst_n), .avs_address(avs_address), .avs_write(avs_write),
   .avs_writedata(avs_writedata), .avs_waitrequest(avs_waitrequest),
   .wire_reset(wire_reset), .total_flat(total_flat), .alarm(alarm),
   .update_tick(update_tick));

// ===== verif/twa_src.sv
`timescale 1ns/1ps
// ***********
// wired sources
// ***********
module twa_src (
   input  wire         mclk,
   output logic [71:0] in_val_flat,
   output logic [3:0]  wire_run,
   output logic [3:0]  wire_hold,
   output logic [3:0]  wire_reset
);
   initial
   begin
      in_val_flat = 72'h0;
      wire_run = 4'h0;
      wire_hold = 4'h0;
      wire_reset = 4'h0;
   end
   task automatic set_in(input int ch, input logic [17:0] v);
      @(posedge mclk);
      in_val_flat[ch*18 +: 18] <= v;
   endtask
   task automatic set_wire(input logic [3:0] r, input logic [3:0] h, input logic [3:0] z);
      @(posedge mclk);
      wire_run <= r;
      wire_hold <= h;
      wire_reset <= z;
   endtask
endmodule // twa_src

// ===== verif/totaliser_with_alarm_tb.sv
`timescale 1ns/1ps
// ***********
// bench
// ***********
module totaliser_with_alarm_tb;
   logic        mclk = 1'b0;
   logic        rst_n = 1'b0;
   logic [7:0]  avs_address = 8'h00;
   logic        avs_read = 1'b0;
   logic        avs_write = 1'b0;
   logic [31:0] avs_writedata = 32'h0;
   logic [3:0]  avs_byteenable = 4'hf;
   logic [31:0] rdata;
   logic [31:0] keep;
   wire  [31:0] avs_readdata;
   wire         avs_waitrequest;
   wire  [71:0] in_val_flat;
   wire  [71:0] total_flat;
   wire  [3:0]  alarm;
   wire  [3:0]  wire_run;
   wire  [3:0]  wire_hold;
   wire  [3:0]  wire_reset;
   wire         update_tick;
   int          fail_count = 0;
   int          samples_checked = 0;
   int          cycles = 0;
   initial
   begin
      forever #4 mclk = ~mclk;
   end
   twa_top #(.TICK_CYCLES(24'd8)) i_dut (
      .mclk(mclk), .rst_n(rst_n), .avs_address(avs_address), .avs_read(avs_read),
      .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
      .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
      .in_val_flat(in_val_flat), .wire_run(wire_run), .wire_hold(wire_hold),
      .wire_reset(wire_reset), .total_flat(total_flat), .alarm(alarm),
      .update_tick(update_tick));
   twa_src i_src (.mclk(mclk), .in_val_flat(in_val_flat), .wire_run(wire_run),
      .wire_hold(wire_hold), .wire_reset(wire_reset));
   task automatic report_and_stop;
      $display("compares %0d mismatches %0d", samples_checked, fail_count);
      if (fail_count == 0 && samples_checked > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp)
      begin
         fail_count++;
         $display("unexpected at %0t: got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
                      input logic [3:0] be);
      @(posedge mclk);
      avs_address <= a;
      avs_writedata <= d;
      avs_byteenable <= be;
      avs_write <= w;
      avs_read <= ~w;
      do
         @(posedge mclk);
      while (avs_waitrequest !== 1'b0);
      rdata = avs_readdata;
      avs_write <= 1'b0;
      avs_read <= 1'b0;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      bus(1'b1, a, d, 4'hf);
   endtask
   task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
      bus(1'b0, a, 32'h0, 4'hf);
      chk(rdata, exp);
   endtask
   always @(posedge mclk)
   begin
      cycles++;
      if (cycles == 20000)
      begin
         fail_count++;
         report_and_stop();
      end
   end
   initial
   begin
      repeat (10) @(posedge mclk);
      rst_n <= 1'b1;
      for (int ch = 0; ch < 4; ch++)
      begin
         rdc(8'(ch * 16), 32'h2);
         rdc(8'(ch * 16 + 4), 32'h0);
         rdc(8'(ch * 16 + 12), 32'h0);
      end
      rdc(8'h40, 32'h0);
      $display("reset test done");
      i_src.set_in(0, 18'h1fc00);
      wr(8'h04, 32'h12c);
      wr(8'h00, 32'h1);
      repeat (40) @(posedge mclk);
      chk({28'h0, alarm}, 32'h1);
      rdc(8'h0c, 32'h3);
      wr(8'h00, 32'h3);
      bus(1'b0, 8'h08, 32'h0, 4'hf);
      keep = rdata;
      repeat (40) @(posedge mclk);
      rdc(8'h08, keep);
      rdc(8'h0c, 32'h5);
      wr(8'h04, 32'h12c);
      rdc(8'h0c, 32'h5);
      wr(8'h04, 32'h0);
      rdc(8'h0c, 32'h4);
      wr(8'h00, 32'h6);
      rdc(8'h08, 32'h0);
      bus(1'b1, 8'h00, 32'h1, 4'he);
      rdc(8'h00, 32'h2);
      $display("run hold test done");
      i_src.set_in(1, 18'h1fc00);
      i_src.set_in(2, 18'h20400);
      wr(8'h24, 32'h3ec78);
      wr(8'h10, 32'h1);
      wr(8'h20, 32'h1);
      repeat (7000) @(posedge mclk);
      rdc(8'h18, 32'h1869f);
      rdc(8'h1c, 32'h2);
      rdc(8'h28, 32'h3d8f1);
      rdc(8'h2c, 32'h3);
      rdc(8'h24, 32'h3ec78);
      rdc(8'h38, 32'h0);
      $display("limit test done");
      i_src.set_in(3, 18'h00800);
      wr(8'h30, 32'h70);
      i_src.set_wire(4'h8, 4'h0, 4'h0);
      rdc(8'h3c, 32'h2);
      bus(1'b0, 8'h38, 32'h0, 4'hf);
      keep = rdata;
      repeat (37) @(posedge mclk);
      rdc(8'h38, keep + 32'd10);
      i_src.set_wire(4'h8, 4'h8, 4'h0);
      rdc(8'h3c, 32'h4);
      i_src.set_wire(4'h8, 4'h0, 4'h8);
      rdc(8'h38, 32'h0);
      i_src.set_wire(4'h0, 4'h0, 4'h0);
      wr(8'h30, 32'h71);
      rdc(8'h3c, 32'h0);
      $display("wired test done");
      report_and_stop();
   end
endmodule // totaliser_with_alarm_tb
